// File: dma_write_command_handler_tb.sv
// self-checking bench for the dma write command block
`timescale 1ns/1ps
`default_nettype none
`include "dwc_regs.svh"
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end

module dma_write_command_handler_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        dmarq, dmack, dma_crc_err, media_start, media_done, media_fail;
    logic        stall_en, crc_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, fail_at;
    logic [15:0] dma_wdata;
    logic [27:0] media_addr;
    logic [32:0] exp_q [$];
    logic [32:0] got_e;
    string       nm_q [$];
    string       got_n;
    int          fail_count, total_checks, base;

    dwc_write_cmd u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .dmarq, .dmack, .dma_wdata, .dma_crc_err,
        .media_start, .media_addr, .media_done, .media_fail, .irq);
    dwc_host_model u_host (.pclk, .presetn, .stall_en, .crc_en, .fail_at, .dmarq, .dmack,
        .dma_wdata, .dma_crc_err, .media_start, .media_addr, .media_done, .media_fail);

    initial
    begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
        begin
            got_e = exp_q.pop_front();
            got_n = nm_q.pop_front();
            `CHK(got_n, got_e, {pslverr, prdata})
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input string nm, input logic [32:0] e);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
        begin
            exp_q.push_back(e);
            nm_q.push_back(nm);
        end
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!pready && n < 64);
        `CHK("pready", 1'h1, pready)
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, "", 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input string nm, input logic [32:0] e);
        apb(1'h0, a, 32'h0, nm, e);
    endtask : rd

    task automatic tfile(input logic [7:0] sc, sn, cl, ch, dh);
        wr(`DWC_OFF_SCNT, {24'h0, sc});
        wr(`DWC_OFF_SNUM, {24'h0, sn});
        wr(`DWC_OFF_CYLL, {24'h0, cl});
        wr(`DWC_OFF_CYLH, {24'h0, ch});
        wr(`DWC_OFF_DEVH, {24'h0, dh});
    endtask : tfile

    task automatic wait_rq(input logic v);
        int n;
        n = 0;
        while (dmarq !== v && n < 4000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("dmarq", v, dmarq)
    endtask : wait_rq

    // the host model start count is sampled before the opcode write, then irq is awaited and cleared
    task automatic cmd(input logic [7:0] op);
        int n;
        base = u_host.nstart;
        wr(`DWC_OFF_CMD, {24'h0, op});
        n = 0;
        while (irq !== 1'h1 && n < 70000)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("irq", 1'h1, irq)
        wr(`DWC_OFF_ISTS, 32'h3);
        @(posedge pclk);
        `CHK("irq clear", 1'h0, irq)
    endtask : cmd

    initial
    begin
        #400000;
        fail_count++;
        test_done();
    end

    initial
    begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        stall_en = 1'h1;
        crc_en = 1'h0;
        fail_at = '1;
        void'($urandom(75));
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(`DWC_OFF_STAT, "status", 33'h50);
        wr(`DWC_OFF_ERR, 32'hFF);
        rd(`DWC_OFF_ERR, "error", 33'h0);
        rd(8'h3C, "unmapped", 33'h100000000);
        $display("test reset done");

        base = u_host.nstart;
        wr(`DWC_OFF_CMD, {24'h0, `DWC_OP_BUFW});
        wait_rq(1'h1);
        wait_rq(1'h0);
        repeat (3) @(posedge pclk);
        `CHK("irq masked", 1'h0, irq)
        rd(`DWC_OFF_ISTS, "int status", 33'h1);
        wr(`DWC_OFF_IMSK, 32'h1);
        @(posedge pclk);
        `CHK("irq unmasked", 1'h1, irq)
        wr(`DWC_OFF_ISTS, 32'h1);
        @(posedge pclk);
        `CHK("irq w1c", 1'h0, irq)
        `CHK("media starts", base, u_host.nstart)
        rd(`DWC_OFF_STAT, "status", 33'h50);
        for (int i = 0; i < 256; i++)
            rd(`DWC_OFF_BUFRD, "buffer word", {17'h0, u_host.mem[i]});
        wr(`DWC_OFF_IMSK, 32'h3);
        stall_en <= 1'h0;
        $display("test buffer write done");

        // lba start one below a carry into the high cylinder byte
        for (int i = 0; i < 2; i++)
        begin
            tfile(8'h02, 8'hFF, 8'hFF, 8'h12, 8'h45);
            cmd(`DWC_OP_MEDW | 8'(i));
            `CHK("starts", base + 2, u_host.nstart)
            `CHK("lba", 28'h5130000, u_host.last_addr)
            rd(`DWC_OFF_SCNT, "count", 33'h0);
            rd(`DWC_OFF_SNUM, "sector", 33'h0);
            rd(`DWC_OFF_CYLL, "cyl low", 33'h0);
            rd(`DWC_OFF_CYLH, "cyl high", 33'h13);
        end
        $display("test media write lba done");

        tfile(8'h01, 8'h05, 8'h02, 8'h01, 8'h02);
        cmd(`DWC_OP_MEDW);
        `CHK("chs", 28'h2010205, u_host.last_addr)
        rd(`DWC_OFF_SNUM, "sector", 33'h05);
        rd(`DWC_OFF_CYLL, "cyl low", 33'h02);
        rd(`DWC_OFF_CYLH, "cyl high", 33'h01);
        // last sector of the last head: sector wraps to one, cylinder steps
        tfile(8'h02, 8'h3F, 8'h02, 8'h01, 8'h0F);
        cmd(`DWC_OP_MEDW);
        `CHK("chs wrap", 28'h0010301, u_host.last_addr)
        rd(`DWC_OFF_SNUM, "sector", 33'h01);
        rd(`DWC_OFF_CYLL, "cyl low", 33'h03);
        rd(`DWC_OFF_DEVH, "head", 33'h00);
        $display("test media write chs done");

        tfile(8'h03, 8'h10, 8'h00, 8'h00, 8'h40);
        fail_at <= u_host.nstart + 2;
        cmd(`DWC_OP_MEDW);
        fail_at <= '1;
        `CHK("starts", base + 2, u_host.nstart)
        rd(`DWC_OFF_ERR, "error", 33'h14);
        rd(`DWC_OFF_SCNT, "count", 33'h02);
        rd(`DWC_OFF_SNUM, "sector", 33'h11);
        rd(`DWC_OFF_STAT, "status", 33'h51);
        cmd(8'h00);
        rd(`DWC_OFF_ERR, "error", 33'h04);
        crc_en <= 1'h1;
        cmd(`DWC_OP_MEDW);
        crc_en <= 1'h0;
        `CHK("starts", base, u_host.nstart)
        rd(`DWC_OFF_ERR, "error", 33'h84);
        rd(`DWC_OFF_SCNT, "count", 33'h02);
        $display("test media fail done");

        tfile(8'h00, 8'h00, 8'h00, 8'h00, 8'h40);
        cmd(`DWC_OP_MEDW | 8'h01);
        `CHK("starts", base + 256, u_host.nstart)
        rd(`DWC_OFF_SCNT, "count", 33'h0);
        rd(`DWC_OFF_SNUM, "sector", 33'hFF);
        rd(`DWC_OFF_STAT, "status", 33'h50);
        $display("test full count done");
        test_done();
    end
endmodule : dma_write_command_handler_tb
`default_nettype wire

// File: dwc_host_model.sv
// host slave-dma channel and media back end facing the write command block
`timescale 1ns/1ps
`default_nettype none

module dwc_host_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        stall_en,
    input  wire logic        crc_en,
    input  wire logic [31:0] fail_at,
    input  wire logic        dmarq,
    output logic             dmack,
    output logic [15:0]      dma_wdata,
    output logic             dma_crc_err,
    input  wire logic        media_start,
    input  wire logic [27:0] media_addr,
    output logic             media_done,
    output logic             media_fail
);
    logic [15:0] mem [256];
    logic [27:0] last_addr;
    int          wcnt;
    int          nstart;
    int          dly;
    int          taken;
    logic        go;

    // a corrupted word is flagged on the very transfer that carries it
    assign dma_crc_err = crc_en && dmack;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dmack <= 1'h0;
            dma_wdata <= 16'h0000;
            media_done <= 1'h0;
            media_fail <= 1'h0;
            wcnt = 0;
            nstart = 0;
            dly = 0;
        end
        else
        begin
            taken = wcnt + int'(dmarq && dmack);
            if (dmarq && dmack)
                mem[wcnt] <= dma_wdata;
            // an aborted sector must not leave the word count out of step
            wcnt = (taken == 256 || !dmarq) ? 0 : taken;
            go = dmarq && taken != 256 && !dma_crc_err && !(stall_en && $urandom_range(3) == 0);
            dmack <= go;
            // an idle data bus keeps toggling so a stale word never looks valid
            dma_wdata <= go ? 16'($urandom) : ~dma_wdata;
            media_done <= dly == 1;
            media_fail <= (dly == 1) ? nstart == int'(fail_at) : ~media_fail;
            if (dly > 0)
                dly = dly - 1;
            if (media_start)
            begin
                nstart = nstart + 1;
                last_addr <= media_addr;
                dly = 1 + $urandom_range(2);
            end
        end
    end
endmodule : dwc_host_model
`default_nettype wire

// File: dwc_pkg.sv
// state types of the dma write command block
package dwc_pkg;

    typedef enum logic [2:0] {
        DWC_IDLE,
        DWC_XFER,
        DWC_REQ,
        DWC_WAIT,
        DWC_DONE
    } dwc_state_type;

    typedef struct packed {
        dwc_state_type st;
        logic [7:0]    sc;
        logic [7:0]    sn;
        logic [7:0]    cl;
        logic [7:0]    ch;
        logic [7:0]    dh;
        logic [7:0]    err;
        logic [7:0]    wcnt;
        logic [7:0]    rptr;
        logic [8:0]    left;
        logic          media;
        logic          rdy;
        logic [1:0]    ists;
        logic [1:0]    imsk;
    } dwc_regs_type;

endpackage : dwc_pkg

// File: dwc_regs.svh
// register offsets, field positions and constants of the dma write command block
`ifndef DWC_REGS_SVH
`define DWC_REGS_SVH

`define DWC_OFF_BUFRD 8'h00
`define DWC_OFF_ERR   8'h04
`define DWC_OFF_SCNT  8'h08
`define DWC_OFF_SNUM  8'h0C
`define DWC_OFF_CYLL  8'h10
`define DWC_OFF_CYLH  8'h14
`define DWC_OFF_DEVH  8'h18
`define DWC_OFF_CMD   8'h1C
`define DWC_OFF_STAT  8'h20
`define DWC_OFF_ISTS  8'h24
`define DWC_OFF_IMSK  8'h28

`define DWC_OP_BUFW   8'hEB
`define DWC_OP_MEDW   8'hCA

`define DWC_ST_BSY    7
`define DWC_ST_RDY    6
`define DWC_ST_DSC    4
`define DWC_ST_DRQ    3
`define DWC_ST_ERR    0

`define DWC_ER_CRC    8'h80
`define DWC_ER_IDN    8'h10
`define DWC_ER_ABT    8'h04

`define DWC_DEVH_LBA  6
`define DWC_IRQ_DONE  0
`define DWC_IRQ_FAIL  1

`define DWC_WORD_W    16
`define DWC_SEC_WORDS 256
`define DWC_LAST_WORD 8'hFF
`define DWC_MAX_SECT  9'h100
`define DWC_ONE_SECT  9'h001

`endif

// File: dwc_sector_buf.sv
// one-sector word buffer, synchronous write and registered read
`timescale 1ns/1ps
`default_nettype none

module dwc_sector_buf
    import dwc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256,
    parameter int AW    = $clog2(DEPTH)
)
(
    input  wire logic             pclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    generate
        if (DEPTH != (1 << AW) || WIDTH < 1)
        begin : g_bad
            $error("buffer depth must be a power of two");
        end
    endgenerate

    // no reset: contents are only defined once written
    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : dwc_sector_buf

`default_nettype wire

// File: dwc_write_cmd.sv
// buffer-write and media-write dma command handler with apb registers
//
// Behaviour
// RULE_01: opcode EB takes exactly one sector into the buffer, never the media.
// RULE_02: every data word moves as one 16-bit transfer.
// RULE_03: buffer read after a buffer write returns the same 512 bytes.
// RULE_04: opcodes CA and CB decode as the same media write.
// RULE_05: the low retry bit of the media-write opcode changes nothing.
// RULE_06: media write takes one or more sectors, then commits each to media.
// RULE_07: host sets up its dma channel before writing the opcode.
// RULE_08: words move only while dmarq is high.
// RULE_09: exactly one interrupt per command, once status is readable.
// RULE_10: an uncorrectable media error stops at the failing sector.
// RULE_11: sector count gives sectors to write; zero means 256.
// RULE_12: with lba clear, address is sector, cylinder pair and head.
// RULE_13: with lba set, a 28-bit address from the four registers.
// RULE_14: at completion sector count holds sectors not transferred.
// RULE_15: at completion address registers hold the last sector touched.
// RULE_16: at completion busy and fault clear, error set with abort.
// RULE_17: media write reports only crc, not-found and abort flags.
`timescale 1ns/1ps
`default_nettype none
`include "dwc_regs.svh"

module dwc_write_cmd
    import dwc_pkg::*;
#(
    parameter logic [7:0] SECT_PER_TRK = 8'h3F,
    parameter logic [4:0] NUM_HEADS    = 5'h10
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             dmarq,
    input  wire logic        dmack,
    input  wire logic [15:0] dma_wdata,
    input  wire logic        dma_crc_err,
    output logic             media_start,
    output logic      [27:0] media_addr,
    input  wire logic        media_done,
    input  wire logic        media_fail,
    output logic             irq
);

    dwc_regs_type s;
    dwc_regs_type s_nxt;

    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic        buf_we;
    logic [15:0] buf_rdata;
    logic [7:0]  op;
    logic [7:0]  status;
    logic [27:0] lba_cur;
    logic [27:0] lba_inc;
    logic [15:0] cyl_inc;

    generate
        if (SECT_PER_TRK == 8'h00 || NUM_HEADS == 5'h00 || NUM_HEADS > 5'h10)
        begin : g_bad
            $error("geometry parameters out of range");
        end
    endgenerate

    // one wait state on every access keeps the buffer read in step
    assign acc    = psel & penable & s.rdy;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign op     = pwdata[7:0];

    // RULE_08 words only under dmarq
    assign buf_we = (s.st == DWC_XFER) & dmack & ~dma_crc_err;

    assign dmarq       = (s.st == DWC_XFER);
    assign media_start = (s.st == DWC_REQ);
    assign lba_cur     = {s.dh[3:0], s.ch, s.cl, s.sn};
    assign lba_inc     = lba_cur + 28'h0000001;
    assign cyl_inc     = {s.ch, s.cl} + 16'h0001;
    assign media_addr  = lba_cur;
    assign pready      = s.rdy;
    assign irq         = |(s.ists & s.imsk);

    // RULE_16 status with busy, fault bit left clear
    always_comb
    begin
        status                = 8'h00;
        status[`DWC_ST_BSY]   = (s.st != DWC_IDLE);
        status[`DWC_ST_RDY]   = 1'b1;
        status[`DWC_ST_DSC]   = 1'b1;
        status[`DWC_ST_DRQ]   = dmarq;
        status[`DWC_ST_ERR]   = (s.err != 8'h00);
    end

    // RULE_02 sixteen-bit word path
    dwc_sector_buf #(
        .WIDTH (`DWC_WORD_W),
        .DEPTH (`DWC_SEC_WORDS)
    ) u_buf (
        .pclk  (pclk),
        .we    (buf_we),
        .waddr (s.wcnt),
        .wdata (dma_wdata),
        .raddr (s.rptr),
        .rdata (buf_rdata)
    );

    always_comb
    begin
        hit    = 1'b1;
        prdata = 32'h00000000;
        case (paddr)
            `DWC_OFF_BUFRD: prdata[15:0] = buf_rdata;
            `DWC_OFF_ERR:   prdata[7:0]  = s.err;
            `DWC_OFF_SCNT:  prdata[7:0]  = s.sc;
            `DWC_OFF_SNUM:  prdata[7:0]  = s.sn;
            `DWC_OFF_CYLL:  prdata[7:0]  = s.cl;
            `DWC_OFF_CYLH:  prdata[7:0]  = s.ch;
            `DWC_OFF_DEVH:  prdata[7:0]  = s.dh;
            `DWC_OFF_CMD:   prdata[7:0]  = status;
            `DWC_OFF_STAT:  prdata[7:0]  = status;
            `DWC_OFF_ISTS:  prdata[1:0]  = s.ists;
            `DWC_OFF_IMSK:  prdata[1:0]  = s.imsk;
            default:        hit          = 1'b0;
        endcase
        pslverr = s.rdy & ~hit;
    end

    always_comb
    begin
        s_nxt     = s;
        s_nxt.rdy = psel & penable & ~s.rdy;

        if (wr_acc && paddr == `DWC_OFF_IMSK)
        begin
            s_nxt.imsk = pwdata[1:0];
        end
        if (wr_acc && paddr == `DWC_OFF_ISTS)
        begin
            s_nxt.ists = s.ists & ~pwdata[1:0];
        end
        // RULE_03 reads walk the same sector
        if (rd_acc && paddr == `DWC_OFF_BUFRD && s.st == DWC_IDLE)
        begin
            s_nxt.rptr = s.rptr + 8'h01;
        end

        case (s.st)
            DWC_IDLE:
            begin
                // task file is only writable while not busy
                if (wr_acc)
                begin
                    case (paddr)
                        `DWC_OFF_SCNT: s_nxt.sc = op;
                        `DWC_OFF_SNUM: s_nxt.sn = op;
                        `DWC_OFF_CYLL: s_nxt.cl = op;
                        `DWC_OFF_CYLH: s_nxt.ch = op;
                        `DWC_OFF_DEVH: s_nxt.dh = op;
                        default:       s_nxt.sc = s.sc;
                    endcase
                end
                if (wr_acc && paddr == `DWC_OFF_CMD)
                begin
                    s_nxt.err  = 8'h00;
                    s_nxt.wcnt = 8'h00;
                    // RULE_01 buffer write is one sector
                    if (op == `DWC_OP_BUFW)
                    begin
                        s_nxt.media = 1'b0;
                        s_nxt.left  = `DWC_ONE_SECT;
                        s_nxt.rptr  = 8'h00;
                        s_nxt.st    = DWC_XFER;
                    end
                    // RULE_04 both opcodes one command
                    // RULE_05 retry bit dropped
                    else if ({op[7:1], 1'b0} == `DWC_OP_MEDW)
                    begin
                        s_nxt.media = 1'b1;
                        // RULE_11 zero count means 256
                        s_nxt.left  = (s.sc == 8'h00) ? `DWC_MAX_SECT : {1'b0, s.sc};
                        s_nxt.st    = DWC_XFER;
                    end
                    else
                    begin
                        s_nxt.media = 1'b0;
                        s_nxt.left  = 9'h000;
                        s_nxt.err   = `DWC_ER_ABT;
                        s_nxt.st    = DWC_DONE;
                    end
                end
            end
            DWC_XFER:
            begin
                // RULE_17 link crc error aborts
                if (dmack && dma_crc_err)
                begin
                    s_nxt.err = `DWC_ER_CRC | `DWC_ER_ABT;
                    s_nxt.st  = DWC_DONE;
                end
                else if (dmack)
                begin
                    s_nxt.wcnt = s.wcnt + 8'h01;
                    if (s.wcnt == `DWC_LAST_WORD)
                    begin
                        // RULE_06 sector goes on to media
                        if (s.media)
                        begin
                            s_nxt.st = DWC_REQ;
                        end
                        else
                        begin
                            s_nxt.left = 9'h000;
                            s_nxt.st   = DWC_DONE;
                        end
                    end
                end
            end
            DWC_REQ:
            begin
                s_nxt.st = DWC_WAIT;
            end
            DWC_WAIT:
            begin
                if (media_done)
                begin
                    // RULE_10 stop at failing sector
                    if (media_fail)
                    begin
                        s_nxt.err = `DWC_ER_IDN | `DWC_ER_ABT;
                        s_nxt.st  = DWC_DONE;
                    end
                    else if (s.left == `DWC_ONE_SECT)
                    begin
                        s_nxt.left = 9'h000;
                        s_nxt.st   = DWC_DONE;
                    end
                    else
                    begin
                        s_nxt.left = s.left - `DWC_ONE_SECT;
                        s_nxt.st   = DWC_XFER;
                        // RULE_13 block address step
                        if (s.dh[`DWC_DEVH_LBA])
                        begin
                            {s_nxt.dh[3:0], s_nxt.ch, s_nxt.cl, s_nxt.sn} = lba_inc;
                        end
                        // RULE_12 sector, head, cylinder step
                        else if (s.sn < SECT_PER_TRK)
                        begin
                            s_nxt.sn = s.sn + 8'h01;
                        end
                        else
                        begin
                            s_nxt.sn = 8'h01;
                            if ({1'b0, s.dh[3:0]} >= NUM_HEADS - 5'h01)
                            begin
                                s_nxt.dh[3:0]      = 4'h0;
                                {s_nxt.ch, s_nxt.cl} = cyl_inc;
                            end
                            else
                            begin
                                s_nxt.dh[3:0] = s.dh[3:0] + 4'h1;
                            end
                        end
                    end
                end
            end
            DWC_DONE:
            begin
                // RULE_14 residual count
                // RULE_15 address left at last sector
                if (s.media)
                begin
                    s_nxt.sc = s.left[7:0];
                end
                s_nxt.st = DWC_IDLE;
            end
            default:
            begin
                s_nxt.st = DWC_IDLE;
            end
        endcase

        // RULE_09 one completion event, set beats clear
        if (s.st == DWC_DONE)
        begin
            s_nxt.ists[`DWC_IRQ_DONE] = 1'b1;
            if (s.err != 8'h00)
            begin
                s_nxt.ists[`DWC_IRQ_FAIL] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= s_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_buf_gated;
        buf_we |-> dmarq && dmack;
    endproperty
    a_buf_gated: assert property (p_buf_gated) // RULE_08
        else $error("buffer written without dmarq");

    property p_one_sector;
        (s.st == DWC_XFER) && !s.media && dmack && !dma_crc_err && s.wcnt == 8'hFF
            |=> (s.st == DWC_DONE) ##1 (s.st == DWC_IDLE) && !dmarq;
    endproperty
    a_one_sector: assert property (p_one_sector) // RULE_01
        else $error("buffer write did not end after one sector");

    property p_retry_ignored;
        (s.st == DWC_IDLE) && wr_acc && paddr == `DWC_OFF_CMD && op[7:1] == 7'h65
            |=> s.media && dmarq;
    endproperty
    a_retry_ignored: assert property (p_retry_ignored) // RULE_05
        else $error("media write opcode not taken");

    property p_zero_count;
        (s.st == DWC_IDLE) && wr_acc && paddr == `DWC_OFF_CMD && op == 8'hCB
            && s.sc == 8'h00 |=> s.left == 9'h100;
    endproperty
    a_zero_count: assert property (p_zero_count) // RULE_11
        else $error("zero sector count not read as 256");

    property p_fail_stop;
        (s.st == DWC_WAIT) && media_done && media_fail
            |=> (s.st == DWC_DONE) ##1 !dmarq && s.sc == $past(s.left[7:0]);
    endproperty
    a_fail_stop: assert property (p_fail_stop) // RULE_10
        else $error("transfer went on after media failure");

    // a clear in the first idle cycle is legal, so only the cycle after done is checked
    property p_one_irq;
        (s.st == DWC_DONE) |=> (s.st != DWC_DONE) && s.ists[`DWC_IRQ_DONE];
    endproperty
    a_one_irq: assert property (p_one_irq) // RULE_09
        else $error("completion not flagged once");

    property p_err_flags;
        (s.st == DWC_DONE) && s.media |-> (s.err & 8'h6B) == 8'h00;
    endproperty
    a_err_flags: assert property (p_err_flags) // RULE_17
        else $error("unexpected media write error flag");

    property p_lba_step;
        (s.st == DWC_WAIT) && media_done && !media_fail && s.left > 9'h001
            && s.dh[`DWC_DEVH_LBA] |=> lba_cur == $past(lba_cur) + 28'h0000001;
    endproperty
    a_lba_step: assert property (p_lba_step) // RULE_13
        else $error("block address did not advance by one");

    property p_done_status;
        (s.st == DWC_DONE) |=> !status[7] && !status[5]
            && status[0] == (s.err != 8'h00);
    endproperty
    a_done_status: assert property (p_done_status) // RULE_16
        else $error("completion status wrong");

endmodule : dwc_write_cmd

`default_nettype wire
